// file: dv/i2c_bus_model.sv
`timescale 1ns/1ns
// Far side of the two-wire bus: one peer that frames bytes.
// Both lines idle high through the pull-ups, and the clock stands
// still between calls, so the bench may stretch any phase it likes.
module i2c_bus_model (
  output logic scl_pin,  // Serial clock line level.
  output logic sda_pin   // Serial data line level.
);
  // ----------------------------------------------------------------
  // Line actions
  // ----------------------------------------------------------------
  // Released lines float to the pull-up level.
  initial begin
    scl_pin = 1'b1;
    sda_pin = 1'b1;
  end

  // Start: data falls while the clock is high.
  task automatic start();
    #17 sda_pin = 1'b0;
    #200 scl_pin = 1'b0;
  endtask

  // Data only moves while the clock is low, then the clock rises.
  // Low and high phases are 200 ns each, so one bit takes 400 ns.
  task automatic put(input logic v);
    #17 sda_pin = v;
    #183 scl_pin = 1'b1;
  endtask

  // Lower the clock after a full high phase.
  task automatic drop();
    #200 scl_pin = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    #17 sda_pin = 1'b0;
    #183 scl_pin = 1'b1;
    #200 sda_pin = 1'b1;
  endtask
endmodule

// file: dv/i2c_status_flags_bench.sv
`timescale 1ns/1ns
module i2c_status_flags_bench
  import i2c_flag_pkg::*;
();
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;  // 20 MHz system clock.
  logic nrst = 1'b0;  // Reset, active low.
  wire scl_pin;  // Clock line from the peer.
  wire sda_pin;  // Data line from the peer.
  core_stat_t core = '0;  // Controller status.
  logic [ADDR_W-1:0] addr = '0;  // Register address.
  logic [DATA_W-1:0] wdata = '0;  // Write data.
  logic wr_en = 1'b0;  // Write strobe.
  logic rd_en = 1'b0;  // Read strobe.
  logic [DATA_W-1:0] rdata;  // Read data.
  logic [7:0] tx_byte;  // Transmit register.
  wire tx_load;  // Load pulse to the shifter.
  int loads = 0;  // Load pulses seen.
  logic module_en;  // Enable bit.
  logic irq;  // Interrupt level.
  logic rd_q = 1'b0;  // A read answer is due.
  logic [15:0] exp_q[$];  // Expected read data, oldest first.
  int fails = 0;  // Mismatches.
  int checked = 0;  // Comparisons.
  int seed = 32'hd1f81911;  // Fixed seed.
  logic [7:0] b1;  // Random bytes.
  logic [7:0] b2;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  i2c_bus_model bus (.scl_pin(scl_pin), .sda_pin(sda_pin));

  i2c_status_flags DUT (.clk_sys(clk_sys), .nrst(nrst),
    .scl_pin(scl_pin), .sda_pin(sda_pin), .core(core), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .tx_load(tx_load), .tx_byte(tx_byte), .module_en(module_en), .irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] bv(input int b);
    return 16'h0001 << b;
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // The answer is judged by the monitor one cycle later.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask

  // One-cycle pulses of ten-bit match, general call and byte done.
  task automatic hit(input logic [2:0] p, input logic [7:0] b);
    @(posedge clk_sys);
    core.ten_bit_hit <= p[2];
    core.gen_call_hit <= p[1];
    core.rx_done <= p[0];
    core.rx_byte <= b;
    @(posedge clk_sys);
    core.ten_bit_hit <= 1'b0;
    core.gen_call_hit <= 1'b0;
    core.rx_done <= 1'b0;
  endtask

  // Eight data bits, leaving the clock low in the acknowledge phase.
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bus.put(b[i]);
      bus.drop();
    end
    idle(8);
  endtask

  task automatic wrap_up();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_sys) begin
    if (rd_q) begin
      cmp(rdata, exp_q.pop_front());
    end
    rd_q <= rd_en;
  end

  // Each accepted transmit write must give exactly one load pulse.
  always @(posedge clk_sys) begin
    if (tx_load === 1'b1) begin
      loads++;
    end
  end

  // The sequence needs about 350 cycles; the 8000-cycle limit is far beyond that.
  initial begin
    #400000;
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(FLAGS_OFS, FLAGS_RST);
    rd(5'h1c, 16'h0000);
    wr(CTRL_OFS, 16'h0001);
    wr(IMASK_OFS, 16'h000f);
    idle(1);
    cmp({15'h0, module_en}, 16'h0001);
    $display("test reset and map done");
    // A second load while full is refused and flagged.
    b1 = 8'($random(seed));
    core.master_mode <= 1'b1;
    wr(TX_OFS, {8'h00, b1});
    wr(TX_OFS, {8'h00, ~b1});
    cmp({8'h00, tx_byte}, {8'h00, b1});
    rd(FLAGS_OFS, bv(B_TXF) | bv(B_MTX) | bv(B_WCOL));
    bus.start();
    send(b1);
    rd(FLAGS_OFS, bv(B_MTX) | bv(B_ACKPH) | bv(B_WCOL) |
       bv(B_START));
    cmp({15'h0, irq}, 16'h0001);
    bus.put(1'b1);
    idle(8);
    rd(FLAGS_OFS, bv(B_ACK) | bv(B_WCOL) | bv(B_START));
    bus.drop();
    rd(ISTAT_OFS, bv(I_ACKPH));
    wr(FLAGS_OFS, bv(B_WCOL));
    wr(ISTAT_OFS, 16'h000f);
    idle(2);
    cmp({15'h0, irq}, 16'h0000);
    // Second byte is acknowledged by the peer.
    b2 = 8'($random(seed));
    wr(TX_OFS, {8'h00, b2});
    send(b2);
    bus.put(1'b0);
    idle(8);
    rd(FLAGS_OFS, bv(B_START));
    bus.drop();
    $display("test master transmit done");
    // Neither mode, slave transmit, master transmit, all masked.
    wr(ISTAT_OFS, 16'h000f);
    wr(IMASK_OFS, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      core.master_mode <= (i == 2);
      core.slave_tx <= (i == 1);
      core.sda_release <= 1'b1;
      bus.put(1'b0);
      idle(8);
      rd(FLAGS_OFS, bv(B_START) | (i > 0 ? bv(B_COLL) : 16'h0000));
      wr(FLAGS_OFS, bv(B_COLL));
      bus.drop();
    end
    cmp({15'h0, irq}, 16'h0000);
    wr(IMASK_OFS, bv(I_COLL));
    idle(2);
    cmp({15'h0, irq}, 16'h0001);
    wr(ISTAT_OFS, bv(I_COLL));
    idle(2);
    cmp({15'h0, irq}, 16'h0000);
    core <= '0;
    $display("test collision done");
    // The overflowing byte is dropped and the old one kept.
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    hit(3'b001, b1);
    rd(FLAGS_OFS, bv(B_START) | bv(B_RXF));
    rd(RX_OFS, {8'h00, b1});
    rd(FLAGS_OFS, bv(B_START));
    hit(3'b001, b1);
    hit(3'b001, b2);
    rd(FLAGS_OFS, bv(B_START) | bv(B_RXF) | bv(B_OVF));
    rd(RX_OFS, {8'h00, b1});
    wr(FLAGS_OFS, bv(B_OVF));
    $display("test receive done");
    hit(3'b100, 8'h00);
    hit(3'b010, 8'h00);
    rd(FLAGS_OFS, bv(B_START) | bv(B_TEN) | bv(B_GCALL));
    bus.stop();
    idle(8);
    rd(FLAGS_OFS, bv(B_STOP));
    rd(ISTAT_OFS, bv(I_RX) | bv(I_STOP));
    // Unused bits stay zero even after an all-ones write.
    wr(FLAGS_OFS, 16'hffff);
    wr(CTRL_OFS, 16'h0000);
    rd(FLAGS_OFS, 16'h0000);
    // Two writes were taken and one refused, so two loads were sent.
    cmp(16'(loads), 16'h0002);
    idle(4);
    $display("test stop and disable done");
    wrap_up();
  end
endmodule

// file: rtl/i2c_flag_pkg.sv
package i2c_flag_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry and map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;                 // Byte address width.
  localparam int DATA_W = 16;                // Register data width.
  localparam logic [4:0] FLAGS_OFS = 5'h00;  // Bus status flags.
  localparam logic [4:0] CTRL_OFS = 5'h04;   // Control word.
  localparam logic [4:0] ISTAT_OFS = 5'h08;  // Sticky event status.
  localparam logic [4:0] IMASK_OFS = 5'h0c;  // Event mask.
  localparam logic [4:0] RX_OFS = 5'h10;     // Receive holding register.
  localparam logic [4:0] TX_OFS = 5'h14;     // Transmit register.

  // ----------------------------------------------------------------
  // Field positions of the flag register
  // ----------------------------------------------------------------
  localparam int B_ACK = 15;    // Peer did not acknowledge.
  localparam int B_MTX = 14;    // Master byte plus ack under way.
  localparam int B_ACKPH = 13;  // Bus is in an acknowledge phase.
  localparam int B_COLL = 10;   // Bus collision seen.
  localparam int B_GCALL = 9;   // General call received.
  localparam int B_TEN = 8;     // Ten-bit address matched.
  localparam int B_WCOL = 7;    // Write to busy transmit register.
  localparam int B_OVF = 6;     // Receive overflow.
  localparam int B_STOP = 4;    // Stop seen last.
  localparam int B_START = 3;   // Start seen last.
  localparam int B_RXF = 1;     // Receive holding register full.
  localparam int B_TXF = 0;     // Transmit register full.
  localparam logic [15:0] FLAGS_RST = 16'h0000;  // Flags after reset.

  // ----------------------------------------------------------------
  // Control and interrupt fields
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;   // Module enable bit.
  localparam int IRQ_W = 4;     // Number of interrupt events.
  localparam int I_COLL = 0;    // Collision event.
  localparam int I_ACKPH = 1;   // Acknowledge phase entered.
  localparam int I_RX = 2;      // Byte received.
  localparam int I_STOP = 3;    // Stop condition.

  // Serial clock rising edge that precedes the acknowledge bit.
  localparam logic [3:0] ACK_EDGE_CNT = 4'h8;

  // Status from the rest of the controller, same clock domain.
  typedef struct packed {
    logic master_mode;   // Controller acts as bus master.
    logic slave_tx;      // Controller transmits as slave.
    logic sda_release;   // Controller leaves the data line high.
    logic ten_bit_hit;   // Pulse: ten-bit address matched.
    logic gen_call_hit;  // Pulse: general call address seen.
    logic rx_done;       // Pulse: a received byte is complete.
    logic [7:0] rx_byte; // Byte that came with rx_done.
  } core_stat_t;

  // Line events found by the pin monitor.
  typedef struct packed {
    logic scl_rise;   // Serial clock rose.
    logic scl_fall;   // Serial clock fell.
    logic start_det;  // Start or repeated start.
    logic stop_det;   // Stop condition.
    logic sda_lvl;    // Data line level aligned with the edges.
  } line_ev_t;

endpackage

// file: rtl/i2c_status_flags.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module i2c_status_flags
  import i2c_flag_pkg::*;
(
  input wire logic clk_sys,              // 20 MHz system clock.
  input wire logic nrst,                 // Asynchronous reset, low.
  input wire logic scl_pin,              // Serial clock line level.
  input wire logic sda_pin,              // Serial data line level.
  input core_stat_t core,                // Controller status.
  input wire logic [ADDR_W-1:0] addr,    // Register byte address.
  input wire logic [DATA_W-1:0] wdata,   // Write data.
  input wire logic wr_en,                // Write strobe.
  input wire logic rd_en,                // Read strobe.
  output logic [DATA_W-1:0] rdata,       // Read data, one cycle later.
  output logic tx_load,                  // Pulse: new byte to send.
  output logic [7:0] tx_byte,            // Byte to send.
  output logic module_en,                // Module enable bit.
  output logic irq                       // Level interrupt.
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  line_ev_t lev;                        // Line events.
  logic en_r;                           // Module enable.
  logic [3:0] bit_cnt_r, bit_cnt_nxt;   // Rising edges in this byte.
  logic ack_r, mtx_r, ackph_r, coll_r;  // Upper flag bits.
  logic gcall_r, ten_r, wcol_r, ovf_r;  // Middle flag bits.
  logic stop_r, start_r, rxf_r, txf_r;  // Lower flag bits.
  logic [7:0] rx_hold_r;                // Receive holding register.
  logic [7:0] tx_byte_r;                // Transmit register.
  logic tx_load_r;                      // Load pulse to the shifter.
  logic [IRQ_W-1:0] istat_r, istat_nxt; // Sticky event status.
  logic [IRQ_W-1:0] imask_r;            // Event mask.
  logic irq_r;                          // Interrupt output.
  logic [DATA_W-1:0] rdata_r;           // Read data register.
  logic [DATA_W-1:0] flags_w;           // Packed flag register.
  logic [DATA_W-1:0] rd_mux;            // Selected read word.
  logic [IRQ_W-1:0] ev_w;               // Event vector.

  // True when a write of one hits a clearable bit.
  function automatic logic w1c(input logic hit, input logic [15:0] d,
                               input int pos);
    w1c = hit && d[pos];
  endfunction

  // ----------------------------------------------------------------
  // Line monitor
  // ----------------------------------------------------------------
  line_monitor u_mon (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .ev(lev)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire flags_wr = wr_en && (addr == FLAGS_OFS);
  wire ctrl_wr = wr_en && (addr == CTRL_OFS);
  wire istat_wr = wr_en && (addr == ISTAT_OFS);
  wire imask_wr = wr_en && (addr == IMASK_OFS);
  wire tx_wr = wr_en && (addr == TX_OFS);
  wire rx_rd = rd_en && (addr == RX_OFS);
  // A write to a busy transmit register is refused.
  wire tx_take = en_r && tx_wr && !txf_r;
  wire tx_refuse = en_r && tx_wr && txf_r;
  wire ack_fall = en_r && lev.scl_fall && (bit_cnt_r == ACK_EDGE_CNT);
  wire ack_rise = en_r && lev.scl_rise && (bit_cnt_r == ACK_EDGE_CNT);
  wire rx_ev = en_r && core.rx_done;
  wire stop_ev = en_r && lev.stop_det;
  // A released data line read low on a clock rise means another
  // driver won the bus.
  wire coll_ev = en_r && (core.master_mode || core.slave_tx) &&
                 core.sda_release && lev.scl_rise && !lev.sda_lvl;

  // ----------------------------------------------------------------
  // Bit counter
  // ----------------------------------------------------------------
  // Counts clock rises since start; the ninth rise closes the byte.
  assign bit_cnt_nxt = (!en_r || lev.start_det || lev.stop_det ||
                        ack_rise) ? 4'h0 :
                       lev.scl_rise ? bit_cnt_r + 4'h1 : bit_cnt_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control and acknowledge flags
  // ----------------------------------------------------------------
  // Enable steers every event; dropping it clears the master transmit, transmit full, phase, collision, start and stop flags.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        en_r <= wdata[CTRL_EN];
      end
      if (ack_rise && mtx_r) begin
        ack_r <= lev.sda_lvl;
      end
    end
  end

  // Master transmit runs from the load to the acknowledge clock.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mtx_r <= 1'b0;
    end else begin
      mtx_r <= (tx_take && core.master_mode) ||
               (mtx_r && en_r && !ack_rise);
    end
  end

  // The phase flag runs in every mode; in master mode it is merely
  // not meaningful, which saves a mode gate on the edge logic.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ackph_r <= 1'b0;
    end else begin
      if (ack_fall) begin
        ackph_r <= 1'b1;
      end else if (ack_rise || !en_r) begin
        ackph_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky bus flags
  // ----------------------------------------------------------------
  // Hardware set always beats a software clear in the same cycle.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      coll_r <= 1'b0;
      wcol_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      coll_r <= coll_ev ||
                (coll_r && en_r && !w1c(flags_wr, wdata, B_COLL));
      wcol_r <= tx_refuse || (wcol_r && !w1c(flags_wr, wdata, B_WCOL));
      ovf_r <= (rx_ev && rxf_r) ||
               (ovf_r && !w1c(flags_wr, wdata, B_OVF));
    end
  end

  // Address flags last until the bus is released by a stop.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gcall_r <= 1'b0;
      ten_r <= 1'b0;
    end else begin
      gcall_r <= (en_r && core.gen_call_hit) || (gcall_r && !stop_ev);
      ten_r <= (en_r && core.ten_bit_hit) || (ten_r && !stop_ev);
    end
  end

  // Start and stop show whichever condition came last.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else if (!en_r) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else if (lev.start_det || lev.stop_det) begin
      start_r <= lev.start_det;
      stop_r <= lev.stop_det;
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // An overflowing byte is dropped so the unread one survives.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_hold_r <= 8'h00;
      rxf_r <= 1'b0;
    end else begin
      if (rx_ev && !rxf_r) begin
        rx_hold_r <= core.rx_byte;
      end
      rxf_r <= rx_ev || (rxf_r && !rx_rd);
    end
  end

  // The shifter is told of a new byte by a one-cycle load pulse.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_byte_r <= 8'h00;
      tx_load_r <= 1'b0;
      txf_r <= 1'b0;
    end else begin
      tx_load_r <= tx_take;
      if (tx_take) begin
        tx_byte_r <= wdata[7:0];
      end
      txf_r <= tx_take || (txf_r && en_r && !ack_fall);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev_w[I_COLL] = coll_ev;
  assign ev_w[I_ACKPH] = ack_fall;
  assign ev_w[I_RX] = rx_ev;
  assign ev_w[I_STOP] = stop_ev;
  assign istat_nxt = ev_w |
                     (istat_r & ~(istat_wr ? wdata[IRQ_W-1:0] : '0));

  // The output is formed from next values so it tracks the status.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      if (imask_wr) begin
        imask_r <= wdata[IRQ_W-1:0];
      end
      irq_r <= |(istat_nxt & (imask_wr ? wdata[IRQ_W-1:0] : imask_r));
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unimplemented flag bits stay at the reset pattern, zero.
  always_comb begin
    flags_w = FLAGS_RST;
    flags_w[B_ACK] = ack_r;
    flags_w[B_MTX] = mtx_r;
    flags_w[B_ACKPH] = ackph_r;
    flags_w[B_COLL] = coll_r;
    flags_w[B_GCALL] = gcall_r;
    flags_w[B_TEN] = ten_r;
    flags_w[B_WCOL] = wcol_r;
    flags_w[B_OVF] = ovf_r;
    flags_w[B_STOP] = stop_r;
    flags_w[B_START] = start_r;
    flags_w[B_RXF] = rxf_r;
    flags_w[B_TXF] = txf_r;
  end

  // Unmapped addresses read as zero.
  assign rd_mux = (addr == FLAGS_OFS) ? flags_w :
                  (addr == CTRL_OFS) ? {15'h0000, en_r} :
                  (addr == ISTAT_OFS) ? {12'h000, istat_r} :
                  (addr == IMASK_OFS) ? {12'h000, imask_r} :
                  (addr == RX_OFS) ? {8'h00, rx_hold_r} :
                  (addr == TX_OFS) ? {8'h00, tx_byte_r} : 16'h0000;

  // Data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd_en ? rd_mux : 16'h0000;
    end
  end

  assign rdata = rdata_r;
  assign tx_load = tx_load_r;
  assign tx_byte = tx_byte_r;
  assign module_en = en_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_master_load;
    tx_take && core.master_mode;
  endsequence

  property p_ack_status;
    ack_rise && mtx_r |=> ack_r == $past(lev.sda_lvl);
  endproperty
  a_ack_status: assert property (p_ack_status)
    else $error("ack status not taken at ack clock");

  property p_mtx_span;
    s_master_load |=> mtx_r && txf_r;
  endproperty
  a_mtx_span: assert property (p_mtx_span)
    else $error("master transmit flag not set by load");

  property p_mtx_end;
    ack_rise && !tx_take |=> !mtx_r;
  endproperty
  a_mtx_end: assert property (p_mtx_end)
    else $error("master transmit flag outlived ack");

  property p_ackph_set;
    ack_fall |=> ackph_r ##0 bit_cnt_r == ACK_EDGE_CNT;
  endproperty
  a_ackph_set: assert property (p_ackph_set)
    else $error("ack phase flag not set at eighth fall");

  property p_ackph_clr;
    ack_rise |=> !ackph_r && bit_cnt_r == 4'h0;
  endproperty
  a_ackph_clr: assert property (p_ackph_clr)
    else $error("ack phase flag not cleared at ninth rise");

  property p_coll;
    coll_ev |=> coll_r [*2];
  endproperty
  a_coll: assert property (p_coll)
    else $error("collision flag not held");

  property p_zero_bits;
    rd_en |=> rdata[12:11] == 2'b00;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unused flag bits read nonzero");

  property p_ten_stop;
    stop_ev && !core.ten_bit_hit |=> !ten_r;
  endproperty
  a_ten_stop: assert property (p_ten_stop)
    else $error("ten-bit flag survived stop");

  property p_ovf;
    rx_ev && rxf_r |=> ovf_r && $stable(rx_hold_r);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged or byte overwritten");

  property p_rxf;
    rx_rd && !rx_ev |=> !rxf_r;
  endproperty
  a_rxf: assert property (p_rxf)
    else $error("receive full not cleared by read");

  property p_txf;
    txf_r && ack_fall |=> !txf_r ##1 (tx_load == txf_r);
  endproperty
  a_txf: assert property (p_txf)
    else $error("transmit full not cleared when sent");

  property p_irq;
    irq == |(istat_r & imask_r);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not match status and mask");

endmodule

// file: rtl/line_monitor.sv
`timescale 1ns/1ns
module line_monitor
  import i2c_flag_pkg::*;
(
  input wire logic clk_sys,   // System clock.
  input wire logic nrst,      // Asynchronous reset, active low.
  input wire logic scl_pin,   // Serial clock line level.
  input wire logic sda_pin,   // Serial data line level.
  output line_ev_t ev         // Registered line events.
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic scl_s1_r, scl_s2_r, scl_d_r;  // Clock line stages.
  logic sda_s1_r, sda_s2_r, sda_d_r;  // Data line stages.
  line_ev_t ev_nxt;                   // Events before the register.
  line_ev_t ev_r;                     // Registered events.

  // Both lines idle high, so the stages reset high.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_pin, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_pin, sda_s1_r, sda_s2_r};
    end
  end

  // ----------------------------------------------------------------
  // Edge and condition decode
  // ----------------------------------------------------------------
  // Only the second stage and its delayed copy are compared.
  assign ev_nxt.scl_rise = scl_s2_r && !scl_d_r;
  assign ev_nxt.scl_fall = !scl_s2_r && scl_d_r;
  assign ev_nxt.start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign ev_nxt.stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
  assign ev_nxt.sda_lvl = sda_s2_r;

  // Events are registered so every consumer sees them together.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ev_r <= '{sda_lvl: 1'b1, default: 1'b0};
    end else begin
      ev_r <= ev_nxt;
    end
  end

  assign ev = ev_r;

endmodule
